// ==== analog_comparator_control.sv ====
// Functional notes
// - Trigger style: zero level, one edge
// - Trigger polarity: zero low/falling, one high/rising
// - Falling pulse enable gives falling edge pulses
// - Rising pulse enable gives rising edge pulses
// - Inactive comparator output forced to idle level
// - Plus input codes 0-9 legal, rest reserved
// - Minus input decode, 0xD unlisted
// - Supply scale factor from upper field bits
// - Response speed zero/one/two, three reserved
// - Upper hysteresis in 10 mV steps
// - Lower hysteresis in 10 mV steps
// - Warm-up 1/2/4/8 us, output invalid
// - Pin invert bit inverts pin result
// - State bit one returns comparison result
// - State bit zero is running flag
// - Pin drive enable connects output to pin
// - Pin source: synchronized or unsynchronized output
// - Comparator zero control at offset zero
// - Comparator one route at offset 0x14
// - Synchronized rise raises event unless masked
`timescale 1ns/1ps
`include "acc_defs.svh"

module analog_comparator_control
  import acc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Analog comparator results and interrupt masks
  input wire logic [1:0] cmpRaw,
  input wire logic [1:0] intMask,
  // Analog front-end controls
  output logic [1:0] cmpPower,
  output logic [1:0] muxEnable,
  output logic [1:0][3:0] posSelect,
  output logic [1:0][3:0] negSelect,
  output logic [1:0] negSupply,
  output logic [1:0][1:0] supplyScale,
  output logic [1:0][1:0] respSpeed,
  output logic [1:0][2:0] hystUp,
  output logic [1:0][2:0] hystDown,
  // Event outputs
  output logic [1:0] edgePulse,
  output logic [1:0] trigReq,
  output logic [1:0] syncRiseEvent,
  // Pins
  output logic [1:0] pinOut,
  output logic [1:0] pinOe
);

  localparam int N_CMP = 2;
  localparam logic [10:0] WARM_BASE = 11'(`ACC_WARM_BASE_CYC);

  function automatic acc_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    case (a)
      `ACC_CTRL0_OFF: decodeSel = ACC_SEL_CTRL0;
      `ACC_COMPARATOR_ONE_CONTROL_OFF: decodeSel = ACC_SEL_COMPARATOR_ONE_CONTROL;
      `ACC_STAT0_OFF: decodeSel = ACC_SEL_STAT0;
      `ACC_STAT1_OFF: decodeSel = ACC_SEL_STAT1;
      `ACC_COMPARATOR_ZERO_PIN_ROUTE_OFF: decodeSel = ACC_SEL_COMPARATOR_ZERO_PIN_ROUTE;
      `ACC_ROUTE1_OFF: decodeSel = ACC_SEL_ROUTE1;
      default: decodeSel = ACC_SEL_NONE;
    endcase
  endfunction : decodeSel

  function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    applyStrb = res;
  endfunction : applyStrb

  // Write channel
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awreadyR;
  logic wreadyR;
  logic bvalidR;
  logic [1:0] brespR;

  wire awTake = s_axi_awvalid & awreadyR;
  wire wTake = s_axi_wvalid & wreadyR;
  wire doWrite = awHeld_r & wHeld_r & ~bvalidR;
  wire awHeld_nxt = (awHeld_r | awTake) & ~doWrite;
  wire wHeld_nxt = (wHeld_r | wTake) & ~doWrite;
  wire acc_sel_t wrSel = decodeSel(awAddr_r);
  wire wrMapped = (wrSel != ACC_SEL_NONE);

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awreadyR <= 1'b0;
      wreadyR <= 1'b0;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awreadyR <= ~awHeld_nxt;
      wreadyR <= ~wHeld_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awAddr_r <= '0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else begin
      if (awTake) begin
        awAddr_r <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
    end
  end

  // Writes to state registers are dropped silently but still answer OKAY
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalidR <= 1'b0;
      brespR <= `ACC_RESP_OKAY;
    end else if (doWrite) begin
      bvalidR <= 1'b1;
      brespR <= wrMapped ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalidR <= 1'b0;
    end
  end

  // Read channel
  logic arreadyR;
  logic rvalidR;
  logic [31:0] rdataR;
  logic [1:0] rrespR;
  logic [31:0] ctrl_r [N_CMP];
  logic [31:0] route_r [N_CMP];
  logic [N_CMP-1:0] running;
  logic [N_CMP-1:0] effOut;

  wire arTake = s_axi_arvalid & arreadyR;
  wire rvalid_nxt = (rvalidR & ~s_axi_rready) | arTake;
  wire acc_sel_t rdSel = decodeSel(s_axi_araddr);
  wire [31:0] stat0 = {30'h0, effOut[0], running[0]};
  wire [31:0] stat1 = {30'h0, effOut[1], running[1]};
  wire [31:0] route0Rd = {30'h0, route_r[0][1:0]};
  wire [31:0] route1Rd = {30'h0, route_r[1][1:0]};
  wire [31:0] rdMux =
    (rdSel == ACC_SEL_CTRL0) ? ctrl_r[0] :
    (rdSel == ACC_SEL_COMPARATOR_ONE_CONTROL) ? ctrl_r[1] :
    (rdSel == ACC_SEL_STAT0) ? stat0 :
    (rdSel == ACC_SEL_STAT1) ? stat1 :
    (rdSel == ACC_SEL_COMPARATOR_ZERO_PIN_ROUTE) ? route0Rd :
    (rdSel == ACC_SEL_ROUTE1) ? route1Rd : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalidR <= 1'b0;
      arreadyR <= 1'b0;
      rdataR <= 32'h0000_0000;
      rrespR <= `ACC_RESP_OKAY;
    end else begin
      rvalidR <= rvalid_nxt;
      arreadyR <= ~rvalid_nxt;
      if (arTake) begin
        rdataR <= rdMux;
        rrespR <= (rdSel == ACC_SEL_NONE) ? `ACC_RESP_SLVERR
                                          : `ACC_RESP_OKAY;
      end
    end
  end

  assign s_axi_awready = awreadyR;
  assign s_axi_wready = wreadyR;
  assign s_axi_bvalid = bvalidR;
  assign s_axi_bresp = brespR;
  assign s_axi_arready = arreadyR;
  assign s_axi_rvalid = rvalidR;
  assign s_axi_rdata = rdataR;
  assign s_axi_rresp = rrespR;

  // Per-comparator logic
  for (genvar i = 0; i < N_CMP; i++) begin : gCmp
    acc_state_t state_r;
    acc_state_t state_nxt;
    logic [10:0] warmCnt_r;
    logic sync1_r;
    logic sync2_r;
    logic prevOut_r;
    logic prevSync_r;
    logic edgeR;
    logic trigR;
    logic riseEvR;
    logic pinR;
    logic oeR;
    logic [31:0] c;

    wire acc_sel_t ctrlSel = (i == 0) ? ACC_SEL_CTRL0 : ACC_SEL_COMPARATOR_ONE_CONTROL;
    wire acc_sel_t routeSel = (i == 0) ? ACC_SEL_COMPARATOR_ZERO_PIN_ROUTE : ACC_SEL_ROUTE1;
    assign c = ctrl_r[i];

    // Reserved bits are kept as written; software keeps them zero.
    always_ff @(posedge clk) begin
      if (rst) begin
        ctrl_r[i] <= `ACC_CTRL_RST;
        route_r[i] <= `ACC_ROUTE_RST;
      end else if (doWrite) begin
        if (wrSel == ctrlSel) begin
          ctrl_r[i] <= applyStrb(ctrl_r[i], wData_r, wStrb_r);
        end
        if (wrSel == routeSel) begin
          route_r[i] <= applyStrb(route_r[i], wData_r, wStrb_r);
        end
      end
    end

    // Warm-up length doubles per code step
    wire [1:0] warmCode = c[`ACC_WARM_HI:`ACC_WARM_LO];
    wire [10:0] warmLast = 11'(WARM_BASE << warmCode) - 11'h001;
    wire enBit = c[`ACC_ENABLE];

    always_comb begin
      state_nxt = state_r;
      unique case (state_r)
        ACC_OFF: begin
          if (enBit) begin
            state_nxt = ACC_WARM;
          end
        end
        ACC_WARM: begin
          if (!enBit) begin
            state_nxt = ACC_OFF;
          end else if (warmCnt_r >= warmLast) begin
            state_nxt = ACC_RUN;
          end
        end
        ACC_RUN: begin
          if (!enBit) begin
            state_nxt = ACC_OFF;
          end
        end
        default: state_nxt = ACC_OFF;
      endcase
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        state_r <= ACC_OFF;
        warmCnt_r <= 11'h000;
      end else begin
        state_r <= state_nxt;
        warmCnt_r <= (state_nxt == ACC_WARM) ? warmCnt_r + 11'h001
                                             : 11'h000;
      end
    end

    assign running[i] = (state_r == ACC_RUN);

    // Two-stage synchronizer; the first stage feeds only the second
    always_ff @(posedge clk) begin
      if (rst) begin
        sync1_r <= 1'b0;
        sync2_r <= 1'b0;
      end else begin
        sync1_r <= cmpRaw[i];
        sync2_r <= sync1_r;
      end
    end

    wire idleLvl = c[`ACC_IDLE_LVL];
    // Output during warm-up is invalid, so it shows the idle level too
    assign effOut[i] = running[i] ? sync2_r : idleLvl;
    wire asyncOut = running[i] ? cmpRaw[i] : idleLvl;
    wire riseP = effOut[i] & ~prevOut_r;
    wire fallP = ~effOut[i] & prevOut_r;
    wire pol = c[`ACC_TRIG_POL];
    wire edgeSel = pol ? riseP : fallP;
    wire levelSel = (effOut[i] == pol);
    wire syncRise = running[i] & sync2_r & ~prevSync_r;
    wire srcSel = route_r[i][`ACC_ROUTE_SRC] ? asyncOut : effOut[i];
    wire pinVal = srcSel ^ c[`ACC_PIN_INV];

    always_ff @(posedge clk) begin
      if (rst) begin
        prevOut_r <= 1'b0;
        prevSync_r <= 1'b0;
        edgeR <= 1'b0;
        trigR <= 1'b0;
        riseEvR <= 1'b0;
        pinR <= 1'b0;
        oeR <= 1'b0;
      end else begin
        prevOut_r <= effOut[i];
        prevSync_r <= running[i] & sync2_r;
        edgeR <= (c[`ACC_RISE_EN] & riseP) |
                 (c[`ACC_FALL_EN] & fallP);
        trigR <= c[`ACC_TRIG_STYLE] ? edgeSel : levelSel;
        riseEvR <= syncRise & ~intMask[i];
        pinR <= route_r[i][`ACC_ROUTE_PE] & pinVal;
        oeR <= route_r[i][`ACC_ROUTE_PE];
      end
    end

    // Front-end controls; reserved input codes pass through but clear the mux enable, reserved speed drives slow
    wire [3:0] posCode = c[`ACC_POS_HI:`ACC_POS_LO];
    wire [3:0] negCode = c[`ACC_NEG_HI:`ACC_NEG_LO];
    wire [1:0] spdCode = c[`ACC_SPEED_HI:`ACC_SPEED_LO];
    wire posLegal = (posCode <= `ACC_POS_MAX);
    wire negLegal = (negCode != `ACC_NEG_UNLISTED);
    wire negIsSupply = (negCode == `ACC_NEG_SUPPLY_C) |
                       (negCode == `ACC_NEG_SUPPLY_E) |
                       (negCode == `ACC_NEG_SUPPLY_F);

    assign cmpPower[i] = enBit;
    // Mux enable order is software's duty; the block does not enforce it
    assign muxEnable[i] = c[`ACC_MUX_EN] & posLegal & negLegal;
    assign posSelect[i] = posCode;
    assign negSelect[i] = negCode;
    assign negSupply[i] = negIsSupply;
    assign supplyScale[i] = c[`ACC_SCALE_HI:`ACC_SCALE_HI-1];
    assign respSpeed[i] = (spdCode == `ACC_SPEED_RSVD) ? `ACC_SPEED_SLOW
                                                       : spdCode;
    assign hystUp[i] = c[`ACC_HUP_HI:`ACC_HUP_LO];
    assign hystDown[i] = c[`ACC_HDN_HI:`ACC_HDN_LO];
    assign edgePulse[i] = edgeR;
    assign trigReq[i] = trigR;
    assign syncRiseEvent[i] = riseEvR;
    assign pinOut[i] = pinR;
    assign pinOe[i] = oeR;
  end

endmodule : analog_comparator_control

// ==== acc_defs.svh ====
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Register byte offsets
`define ACC_CTRL0_OFF 8'h00
`define ACC_COMPARATOR_ONE_CONTROL_OFF 8'h04
`define ACC_STAT0_OFF 8'h08
`define ACC_STAT1_OFF 8'h0C
`define ACC_COMPARATOR_ZERO_PIN_ROUTE_OFF 8'h10
`define ACC_ROUTE1_OFF 8'h14

// Control register fields
`define ACC_TRIG_STYLE 31
`define ACC_TRIG_POL 30
`define ACC_FALL_EN 29
`define ACC_RISE_EN 28
`define ACC_IDLE_LVL 27
`define ACC_MUX_EN 26
`define ACC_POS_HI 25
`define ACC_POS_LO 22
`define ACC_NEG_HI 21
`define ACC_NEG_LO 18
`define ACC_SCALE_HI 17
`define ACC_SCALE_LO 12
`define ACC_SPEED_HI 11
`define ACC_SPEED_LO 10
`define ACC_HUP_HI 9
`define ACC_HUP_LO 7
`define ACC_HDN_HI 6
`define ACC_HDN_LO 4
`define ACC_WARM_HI 3
`define ACC_WARM_LO 2
`define ACC_PIN_INV 1
`define ACC_ENABLE 0

// State and route fields
`define ACC_STAT_RESULT 1
`define ACC_STAT_RUN 0
`define ACC_ROUTE_PE 1
`define ACC_ROUTE_SRC 0

// Reset values
`define ACC_CTRL_RST 32'h4000_0000
`define ACC_ROUTE_RST 32'h0000_0000

// Input codes
`define ACC_POS_MAX 4'h9
`define ACC_NEG_UNLISTED 4'hD
`define ACC_NEG_SUPPLY_C 4'hC
`define ACC_NEG_SUPPLY_E 4'hE
`define ACC_NEG_SUPPLY_F 4'hF
`define ACC_SPEED_RSVD 2'h3
`define ACC_SPEED_SLOW 2'h0

// Timing: warm-up base time in us, clock rate in MHz
`define ACC_WARM_BASE_US 1
`define ACC_CLK_MHZ 250
`define ACC_WARM_BASE_CYC (`ACC_WARM_BASE_US * `ACC_CLK_MHZ)

// Bus responses
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2

`endif

// ==== acc_pkg.sv ====
package acc_pkg;

  typedef enum logic [2:0] {
    ACC_OFF  = 3'h1,
    ACC_WARM = 3'h2,
    ACC_RUN  = 3'h4
  } acc_state_t;

  typedef enum logic [6:0] {
    ACC_SEL_NONE   = 7'h01,
    ACC_SEL_CTRL0  = 7'h02,
    ACC_SEL_COMPARATOR_ONE_CONTROL  = 7'h04,
    ACC_SEL_STAT0  = 7'h08,
    ACC_SEL_STAT1  = 7'h10,
    ACC_SEL_COMPARATOR_ZERO_PIN_ROUTE = 7'h20,
    ACC_SEL_ROUTE1 = 7'h40
  } acc_sel_t;

endpackage : acc_pkg

// ==== acc_checker.sv ====
`timescale 1ns/1ps
module acc_checker (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Comparator side
  input wire logic [1:0] cmpRaw,
  input wire logic [1:0] intMask,
  input wire logic [1:0] muxEnable,
  input wire logic [1:0][3:0] posSelect,
  input wire logic [1:0][3:0] negSelect,
  input wire logic [1:0] negSupply,
  input wire logic [1:0][1:0] respSpeed,
  input wire logic [1:0] edgePulse,
  input wire logic [1:0] syncRiseEvent,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  sequence bothTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Four quiet samples flush both sync stages, so no rise can follow
  sequence rawQuiet;
    !cmpRaw[0] [*4];
  endsequence
  wresp_time_a: assert property (bothTaken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  rresp_time_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response not on time");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  pos_reserved_a: assert property (
    posSelect[0] > 4'h9 |-> !muxEnable[0])
    else $error("reserved plus code kept mux on");
  neg_unlisted_a: assert property (
    negSelect[1] == 4'hD |-> !muxEnable[1])
    else $error("unlisted minus code kept mux on");
  supply_decode_a: assert property (negSupply[0] ==
    (negSelect[0] == 4'hC || negSelect[0] >= 4'hE))
    else $error("supply reference decode wrong");
  speed_legal_a: assert property (respSpeed[0] != 2'h3)
    else $error("reserved speed code driven");
  pulse_single_a: assert property (edgePulse[0] |=> !edgePulse[0])
    else $error("edge pulse longer than one cycle");
  event_quiet_a: assert property (rawQuiet |=> !syncRiseEvent[0])
    else $error("event without a raw rise");
  mask_block_a: assert property (intMask[0] && $past(intMask[0])
    && $past(intMask[0], 2) |-> !syncRiseEvent[0])
    else $error("masked event seen");
  pin_off_a: assert property (!pinOe[0] |-> !pinOut[0])
    else $error("pin driven while disabled");
endmodule : acc_checker

bind analog_comparator_control acc_checker chk (.*);

// ==== analog_comparator_control_test.sv ====
`timescale 1ns/1ps
module analog_comparator_control_test;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
  } acc_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] cmpRaw = 2'h0;
  logic [1:0] intMask = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmpPower, muxEnable, negSupply;
  logic [31:0] s_axi_rdata, rv;
  logic [1:0][3:0] posSelect, negSelect;
  logic [1:0][1:0] supplyScale, respSpeed;
  logic [1:0][2:0] hystUp, hystDown;
  logic [1:0] edgePulse, trigReq, syncRiseEvent, pinOut, pinOe, rr;
  int miscompares = 0;
  int samplesChecked = 0;
  int n, k, m;
  acc_row_t rows [7] = '{
    '{8'h00, 32'hF7FF_FFFE, 32'hF7FF_FFFE, 2'h0},
    '{8'h04, 32'h0672_5AB8, 32'h0672_5AB8, 2'h0},
    '{8'h08, 32'h0000_0003, 32'h0000_0000, 2'h0},
    '{8'h0C, 32'h0000_0003, 32'h0000_0000, 2'h0},
    '{8'h10, 32'h0000_0002, 32'h0000_0002, 2'h0},
    '{8'h14, 32'h0000_0001, 32'h0000_0001, 2'h0},
    '{8'h18, 32'h0000_0001, 32'h0000_0000, 2'h2}};

  analog_comparator_control DUT (.*);

  always #2 clk = ~clk;

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic endOfTest;
    $display("Checked %0d, bad %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : endOfTest

  // Address and data may be taken at different edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'h0;
    dd = 1'h0;
    @(posedge clk);
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (s_axi_awready) ad = 1'h1;
      if (s_axi_wready) dd = 1'h1;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic watch(input int c);
    n = 0;
    k = 0;
    m = 0;
    repeat (c) begin
      @(posedge clk);
      n += edgePulse[0];
      k += syncRiseEvent[0];
      m += trigReq[0];
    end
  endtask : watch

  initial begin
    #80000;
    miscompares++;
    $display("Watchdog expired");
    endOfTest();
  end

  initial begin
    cyc(12);
    rst <= 1'h0;
    cyc(2);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", rr, rows[i].r);
      rd(rows[i].a);
      chk("rdata", rv, rows[i].q);
      chk("rresp", rr, rows[i].r);
    end
    $display("Row table done");
    chk("pos", posSelect[1], 4'h9);
    chk("neg", negSelect[1], 4'hC);
    chk("supply", negSupply, 2'h3);
    chk("scale", supplyScale, 4'hB);
    chk("speed", respSpeed, 4'h8);
    chk("hystUp", hystUp, 6'h2F);
    chk("hystDown", hystDown, 6'h1F);
    chk("mux", muxEnable, 2'h2);
    $display("Field test done");
    rst <= 1'h1;
    cyc(12);
    rst <= 1'h0;
    cyc(2);
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk("resetval", rv, i < 2 ? 32'h4000_0000 : 32'h0);
    end
    chk("pinOe", pinOe, 2'h0);
    chk("powerRst", cmpPower, 2'h0);
    // Only the low byte is enabled; the rest keeps its reset value
    s_axi_wstrb <= 4'h1;
    wr(8'h04, 32'hFFFF_FFF0);
    s_axi_wstrb <= 4'hF;
    rd(8'h04);
    chk("strobe", rv, 32'h4000_00F0);
    $display("Reset test done");
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h4800_0000);
    cyc(4);
    chk("idle", pinOut[0], 1'h1);
    chk("pinOe", pinOe[0], 1'h1);
    wr(8'h00, 32'h4800_0002);
    cyc(4);
    chk("invert", pinOut[0], 1'h0);
    // Mux first, comparator second, warm-up code 2
    wr(8'h00, 32'h5400_0008);
    wr(8'h00, 32'h5400_0009);
    cyc(940);
    rd(8'h08);
    chk("warming", rv, 32'h0);
    cyc(60);
    rd(8'h08);
    chk("running", rv, 32'h1);
    chk("power", cmpPower, 2'h1);
    cmpRaw <= 2'h1;
    watch(8);
    chk("risePulse", n, 1);
    chk("event", k, 1);
    chk("trigLevel", trigReq[0], 1'h1);
    rd(8'h08);
    chk("result", rv, 32'h3);
    chk("pinSync", pinOut[0], 1'h1);
    cmpRaw <= 2'h0;
    watch(8);
    chk("fallPulse", n, 0);
    intMask <= 2'h1;
    cyc(3);
    cmpRaw <= 2'h1;
    watch(8);
    chk("maskedEvent", k, 0);
    $display("Run test done");
    wr(8'h10, 32'h3);
    cmpRaw <= 2'h0;
    cyc(2);
    chk("pinAsync", pinOut[0], 1'h0);
    // Edge style, low polarity, falling pulses only, still enabled
    wr(8'h00, 32'hA400_0009);
    cmpRaw <= 2'h1;
    cyc(8);
    cmpRaw <= 2'h0;
    watch(8);
    chk("fallPulseOn", n, 1);
    chk("edgeTrig", m, 1);
    chk("trigIdle", trigReq[0], 1'h0);
    wr(8'h00, 32'h5400_0008);
    rd(8'h08);
    chk("stopped", rv, 32'h0);
    chk("powerOff", cmpPower, 2'h0);
    $display("Route and stop test done");
    endOfTest();
  end
endmodule : analog_comparator_control_test
